/* rtl/lsm_decide.sv */
`timescale 1ns/10ps
module lsm_decide
  import lsm_pkg::*;
(
  input wire lsm_op_t op_i,
  input wire logic noncache_i,
  input wire lsm_mesi_t state_i,
  output lsm_act_t act_o
);
  always_comb begin
    act_o = '0;
    act_o.next_state = state_i;
    if (state_i != LSM_I) begin
      unique case (op_i)
        LSM_OP_SNOOP: begin
          act_o.tag_hit = 1'b1;
          if (state_i == LSM_M) begin
            act_o.mod_hit = 1'b1;
            act_o.inquire = 1'b1;
            act_o.writeback = 1'b1;
            act_o.next_state = noncache_i ? LSM_E : LSM_S;
          end else if (state_i == LSM_E && !noncache_i) begin
            act_o.next_state = LSM_S;
          end
        end
        LSM_OP_SNOOP_INV: begin
          act_o.tag_hit = 1'b1;
          act_o.back_inv = 1'b1;
          act_o.mod_hit = (state_i == LSM_M);
          act_o.inquire = (state_i == LSM_M);
          act_o.writeback = (state_i == LSM_M);
          act_o.next_state = LSM_I;
        end
        LSM_OP_SYNC: begin
          if (state_i == LSM_M) begin
            act_o.inquire = 1'b1;
            act_o.writeback = 1'b1;
            act_o.next_state = LSM_E;
          end
        end
        LSM_OP_FLUSH: begin
          act_o.back_inv = 1'b1;
          act_o.inquire = (state_i == LSM_M);
          act_o.writeback = (state_i == LSM_M);
          act_o.next_state = LSM_I;
        end
      endcase
    end // invalid keeps all zero
  end
endmodule // lsm_decide

/* rtl/lsm_pkg.sv */
// Function
// - cacheable snoop on modified: hits, inquire, writeback, shared
// - noncacheable snoop on modified: hits, inquire, writeback, becomes exclusive
// - cacheable snoop on exclusive: tag hit, shared
// - other plain snoop hits: tag hit, state kept
// - invalidating snoop on modified: all, then invalid
// - invalidating snoop on clean: hit, back-invalidate, invalid
// - synchronise: modified written back, becomes exclusive
// - flush: if the indexed line is valid, it goes invalid (modified written back) and the cpu is back-invalidated
package lsm_pkg;
  localparam int LSM_INDEX_W = 4;
  localparam int LSM_TAG_W = 8;

  typedef enum logic [1:0] {
    LSM_I = 2'h0,
    LSM_S = 2'h1,
    LSM_E = 2'h2,
    LSM_M = 2'h3
  } lsm_mesi_t;

  typedef enum logic [1:0] {
    LSM_OP_SNOOP = 2'h0,
    LSM_OP_SNOOP_INV = 2'h1,
    LSM_OP_SYNC = 2'h2,
    LSM_OP_FLUSH = 2'h3
  } lsm_op_t;

  typedef struct packed {
    lsm_mesi_t next_state;
    logic tag_hit;
    logic mod_hit;
    logic inquire;
    logic back_inv;
    logic writeback;
  } lsm_act_t;
endpackage

/* rtl/lsm_top.sv */
`timescale 1ns/10ps
module lsm_top
  import lsm_pkg::*;
#(
  parameter int INDEX_W = LSM_INDEX_W,
  parameter int TAG_W = LSM_TAG_W
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  // request from memory bus controller / maintenance sequencer
  input wire logic req_valid_i,
  input wire lsm_op_t req_op_i,
  input wire logic snoop_noncacheable_flag_i,
  input wire logic [INDEX_W-1:0] req_index_i,
  input wire logic [TAG_W-1:0] req_tag_i,
  // line install port (fills are done elsewhere)
  input wire logic fill_valid_i,
  input wire logic [INDEX_W-1:0] fill_index_i,
  input wire logic [TAG_W-1:0] fill_tag_i,
  input wire lsm_mesi_t fill_state_i,
  // results: one-cycle pulses, plus act_index_o/act_tag_o held until the next request
  output logic done_o,
  output logic tag_hit_ind_o,
  output logic modified_hit_ind_o,
  output logic line_writeback_cycle_o,
  output logic cpu_inquire_cycle_o,
  output logic cpu_back_invalidate_o,
  output logic [INDEX_W-1:0] act_index_o,
  output logic [TAG_W-1:0] act_tag_o
);
  localparam int LINES = 1 << INDEX_W;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    lsm_mesi_t [LINES-1:0] mesi;
    logic [LINES-1:0][TAG_W-1:0] tags;
    logic done;
    logic tag_hit;
    logic mod_hit;
    logic writeback;
    logic inquire;
    logic back_inv;
    logic [INDEX_W-1:0] idx;
    logic [TAG_W-1:0] tag;
  } lsm_state_t;

  lsm_state_t st;
  lsm_state_t next_st;
  lsm_mesi_t look_state;
  lsm_act_t act;

  // snoops must match the tag; sync and flush walk by index only
  always_comb begin
    look_state = st.mesi[req_index_i];
    if ((req_op_i == LSM_OP_SNOOP || req_op_i == LSM_OP_SNOOP_INV)
        && st.tags[req_index_i] != req_tag_i) begin
      look_state = LSM_I;
    end
  end

  lsm_decide u_decide (
    .op_i(req_op_i),
    .noncache_i(snoop_noncacheable_flag_i),
    .state_i(look_state),
    .act_o(act)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.tag_hit = 1'b0;
    next_st.mod_hit = 1'b0;
    next_st.writeback = 1'b0;
    next_st.inquire = 1'b0;
    next_st.back_inv = 1'b0;
    // fill tag always lands; a request that hits a valid line (snoops need a tag match) overrides the fill state; a same-cycle request sees the old line
    if (fill_valid_i) begin
      next_st.mesi[fill_index_i] = fill_state_i;
      next_st.tags[fill_index_i] = fill_tag_i;
    end
    if (req_valid_i) begin
      next_st.done = 1'b1;
      next_st.tag_hit = act.tag_hit;
      next_st.mod_hit = act.mod_hit;
      next_st.writeback = act.writeback;
      next_st.inquire = act.inquire;
      next_st.back_inv = act.back_inv;
      next_st.idx = req_index_i;
      next_st.tag = st.tags[req_index_i];
      if (look_state != LSM_I) begin
        next_st.mesi[req_index_i] = act.next_state;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_o = st.done;
  assign tag_hit_ind_o = st.tag_hit;
  assign modified_hit_ind_o = st.mod_hit;
  assign line_writeback_cycle_o = st.writeback;
  assign cpu_inquire_cycle_o = st.inquire;
  assign cpu_back_invalidate_o = st.back_inv;
  assign act_index_o = st.idx;
  assign act_tag_o = st.tag;
endmodule // lsm_top

/* verif/lsm_chk_sva.sv */
`timescale 1ns/10ps
module lsm_chk
  import lsm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic req_valid_i,
  input wire lsm_op_t req_op_i,
  input wire logic done_o,
  input wire logic tag_hit_ind_o,
  input wire logic modified_hit_ind_o,
  input wire logic line_writeback_cycle_o,
  input wire logic cpu_inquire_cycle_o,
  input wire logic cpu_back_invalidate_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  done_follow_a: assert property (req_valid_i |=> done_o) else $error("no done");
  done_cause_a: assert property (done_o |-> $past(req_valid_i)) else $error("done");
  mod_hit_a: assert property (modified_hit_ind_o |-> tag_hit_ind_o && line_writeback_cycle_o)
    else $error("mhit");
  wb_inq_a: assert property (line_writeback_cycle_o |-> cpu_inquire_cycle_o) else $error("wb");
  cpu_back_invalidate_op_a: assert property (cpu_back_invalidate_o |-> $past(req_op_i[0])) else $error("bi");
  sync_quiet_a: assert property (done_o && $past(req_op_i) == LSM_OP_SYNC |-> !tag_hit_ind_o)
    else $error("sync");
  inq_mod_a: assert property (cpu_inquire_cycle_o && !$past(req_op_i[1]) |-> modified_hit_ind_o)
    else $error("inq");
  hit_done_a: assert property (tag_hit_ind_o |-> done_o) else $error("hit");
endmodule // lsm_chk

bind lsm_top lsm_chk u_chk (.*);

/* verif/lsm_mbc.sv */
`timescale 1ns/10ps
module lsm_mbc (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic wb_i,
  output int count_o
);
  // memory side only tallies write-backs it absorbs
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) count_o <= 0;
    else if (wb_i) count_o <= count_o + 1;
  end
endmodule // lsm_mbc

/* verif/lsm_top_tb.sv */
`timescale 1ns/10ps
module lsm_top_tb;
  import lsm_pkg::*;
  logic mclk_i = 1'h0, rstn_i = 1'h0, req_valid_i = 1'h0, fill_valid_i = 1'h0;
  logic snoop_noncacheable_flag_i = 1'h0;
  lsm_op_t req_op_i = LSM_OP_SNOOP;
  lsm_mesi_t fill_state_i = LSM_I;
  logic [3:0] req_index_i = 4'h0, fill_index_i = 4'h0, act_index_o;
  logic [7:0] req_tag_i = 8'h5a, fill_tag_i = 8'h5a, act_tag_o;
  logic done_o, tag_hit_ind_o, modified_hit_ind_o, line_writeback_cycle_o;
  logic cpu_inquire_cycle_o, cpu_back_invalidate_o;
  int err_total = 0, n_compared = 0, wb_n;
  lsm_top DUT (.*);
  lsm_mbc MBC (.mclk_i, .rstn_i, .wb_i(line_writeback_cycle_o), .count_o(wb_n));
  task automatic chk(input logic [5:0] g, input logic [5:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %b want %b", $time, g, e);
    end
  endtask
  // index and stored tag of the last request, which hold until the next one
  task automatic chk_pos(input logic [11:0] g, input logic [11:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: position %h want %h", $time, g, e);
    end
  endtask
  task automatic fill(input logic [3:0] i, input lsm_mesi_t s);
    @(posedge mclk_i);
    fill_valid_i <= 1'h1;
    fill_index_i <= i;
    fill_state_i <= s;
    @(posedge mclk_i);
    fill_valid_i <= 1'h0;
  endtask
  // pulses judged in the cycle after the request edge
  task automatic req(input logic [1:0] o, input logic n, input logic [3:0] i, input logic [5:0] e);
    @(posedge mclk_i);
    req_valid_i <= 1'h1;
    req_op_i <= lsm_op_t'(o);
    snoop_noncacheable_flag_i <= n;
    req_index_i <= i;
    @(posedge mclk_i);
    req_valid_i <= 1'h0;
    #1 chk({done_o, tag_hit_ind_o, modified_hit_ind_o, line_writeback_cycle_o,
            cpu_inquire_cycle_o, cpu_back_invalidate_o}, e);
  endtask
  task automatic t_snoop;
    fill(4'h1, LSM_M);
    req(2'h0, 1'h0, 4'h1, 6'h3e);
    req(2'h0, 1'h1, 4'h1, 6'h30);
    fill(4'h2, LSM_M);
    req(2'h0, 1'h1, 4'h2, 6'h3e);
    req(2'h0, 1'h0, 4'h2, 6'h30);
    req(2'h0, 1'h0, 4'h9, 6'h20);
    chk_pos({act_index_o, act_tag_o}, 12'h900);
    fill(4'h3, LSM_M);
    req(2'h1, 1'h0, 4'h3, 6'h3f);
    req(2'h0, 1'h0, 4'h3, 6'h20);
    fill(4'h4, LSM_S);
    // wrong tag on a valid line: done only, and the line must survive
    @(posedge mclk_i);
    req_tag_i <= 8'h33;
    req(2'h1, 1'h0, 4'h4, 6'h20);
    chk_pos({act_index_o, act_tag_o}, 12'h45a);
    @(posedge mclk_i);
    req_tag_i <= 8'h5a;
    req(2'h1, 1'h0, 4'h4, 6'h31);
    req(2'h1, 1'h0, 4'h4, 6'h20);
    $display("t_snoop finished");
  endtask
  task automatic t_maint;
    fill(4'h5, LSM_M);
    req(2'h2, 1'h0, 4'h5, 6'h26);
    req(2'h2, 1'h0, 4'h5, 6'h20);
    req(2'h3, 1'h0, 4'h5, 6'h21);
    fill(4'h6, LSM_M);
    req(2'h3, 1'h0, 4'h6, 6'h27);
    req(2'h3, 1'h0, 4'h6, 6'h20);
    chk(wb_n[5:0], 6'h05);
    $display("t_maint finished");
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'h1;
    t_snoop();
    t_maint();
    report_and_stop();
  end
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
endmodule // lsm_top_tb
